/* qcr_pkg.sv */
// Package for the quad channel register banking block
package qcr_pkg;
  localparam int            NUM_CH          = 4;
  localparam logic [7:0]    ADDR_SELECT     = 8'hFF;
  localparam logic [7:0]    ADDR_SH_CHINT   = 8'h05;
  localparam logic [7:0]    ADDR_SOFT_RST   = 8'h00;
  localparam logic [7:0]    ADDR_INT_FLAGS  = 8'h01;
  localparam logic [7:0]    ADDR_REC_STATUS = 8'h02;
  localparam logic [7:0]    ADDR_EQ_BOOST   = 8'h03;
  localparam logic [7:0]    ADDR_CAP_START  = 8'h08;
  localparam int            SEL_BCAST_BIT   = 3;
  localparam int            SEL_CHEN_BIT    = 2;
  localparam int            SOFT_RST_BIT    = 2;
  localparam int            LOCK_LOSS_BIT   = 4;
  localparam int            SD_LOSS_BIT     = 0;
  localparam logic [7:0]    SELECT_RST      = 8'h00;
  localparam logic [7:0]    BOOST_RST       = 8'h00;
  localparam logic [4:0]    CAP_START_RST   = 5'h00;
  localparam logic [7:0]    UNMAPPED_RD     = 8'h00;

  typedef struct packed {
    logic       lock_loss_evt;
    logic       sd_loss_evt;
    logic [7:0] status;
  } qcr_ch_in_t;

  typedef struct packed {
    logic [1:0] boost_stage_zero;
    logic [1:0] boost_stage_one;
    logic [1:0] boost_stage_two;
    logic [1:0] boost_stage_three;
    logic [4:0] cap_start;
    logic       int_pend;
  } qcr_ch_out_t;
endpackage : qcr_pkg

/* qcr_banking.sv */
// Register banking for a four channel retimer: select register, shared and channel sets
// What this block does
// - Broadcast bit set: channel writes update all four channel sets together.
// - Channel reads come only from channel in select bits 1:0.
// - Select bit 2 set routes every other address to the chosen channel set.
// - Host clears select bit 2 to reach shared registers; device routes there.
// - Writes to register_set_select always load the select register; no channel register there.
// - Select register cannot be read back; reads give zero.
// - 0x00 shared, 0x04-0x07 one channel, 0x0C-0x0F broadcast writes.
// - Selection persists until the host writes the select register again.
// - Four independent full channel register copies share one address map.
// - Writing one to bit 2 of channel 0x00 resets that channel; self clears.
// - Channel 0x01 shows lock loss flag bit 4, signal loss bit 0.
// - Channel 0x02 shows eight recovery status bits, read only.
// - Channel 0x03 holds four two-bit boost fields, reset zero.
// - Channel 0x08 bits 4:0 hold the capacitor start override, reset zero.
// - Shared 0x05 bits 3:0 flag interrupts of channels 0 to 3.
// - Select register is zero after reset.
`timescale 1ns/10ps
module qcr_banking #(
  parameter int N_CH = qcr_pkg::NUM_CH
) (
  input  wire logic                               clk,
  input  wire logic                               srst,
  input  wire logic                               reg_wr_en,
  input  wire logic                               reg_rd_en,
  input  wire logic [7:0]                         reg_addr,
  input  wire logic [7:0]                         reg_wdata,
  output logic      [7:0]                         reg_rdata,
  output logic                                    reg_rvalid,
  input  wire qcr_pkg::qcr_ch_in_t  [N_CH-1:0]    ch_in,
  output qcr_pkg::qcr_ch_out_t      [N_CH-1:0]    ch_out
);
  import qcr_pkg::*;

  logic [7:0]      sel_ff;
  logic [7:0]      nxt_sel;
  logic [7:0]      rdata_ff;
  logic [7:0]      nxt_rdata;
  logic            rvalid_ff;
  logic [N_CH-1:0] wr_ch;
  logic [N_CH-1:0] soft_rst;
  logic [7:0]      boost_ff [N_CH];
  logic [4:0]      cap_ff   [N_CH];
  logic [N_CH-1:0] lol_ff;
  logic [N_CH-1:0] sdl_ff;
  logic [7:0]      ch_rd    [N_CH];
  logic [3:0]      sh_chint;
  logic            chan_mode;
  logic [1:0]      rd_ch;

  // Undefined upper select values simply fall through this decode
  assign chan_mode = sel_ff[SEL_CHEN_BIT];
  assign rd_ch     = sel_ff[1:0];

  always_comb begin
    nxt_sel = sel_ff;
    if (reg_wr_en && reg_addr == ADDR_SELECT) begin
      nxt_sel = reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_ff <= SELECT_RST;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  genvar gi;
  generate
    for (gi = 0; gi < N_CH; gi++) begin : g_ch
      logic [7:0] nxt_boost;
      logic [4:0] nxt_cap;
      logic       nxt_lol;
      logic       nxt_sdl;

      // Broadcast or targeted write; register_set_select never reaches a channel
      assign wr_ch[gi] = reg_wr_en && reg_addr != ADDR_SELECT && chan_mode &&
                         (sel_ff[SEL_BCAST_BIT] || rd_ch == 2'(gi));
      assign soft_rst[gi] = wr_ch[gi] && reg_addr == ADDR_SOFT_RST &&
                            reg_wdata[SOFT_RST_BIT];

      always_comb begin
        nxt_boost = boost_ff[gi];
        nxt_cap   = cap_ff[gi];
        if (soft_rst[gi]) begin
          nxt_boost = BOOST_RST;
          nxt_cap   = CAP_START_RST;
        end else if (wr_ch[gi] && reg_addr == ADDR_EQ_BOOST) begin
          nxt_boost = reg_wdata;
        end else if (wr_ch[gi] && reg_addr == ADDR_CAP_START) begin
          nxt_cap   = reg_wdata[4:0];
        end
        // Event beats the reset so a loss in the same cycle is kept
        nxt_lol = (lol_ff[gi] && !soft_rst[gi]) || ch_in[gi].lock_loss_evt;
        nxt_sdl = (sdl_ff[gi] && !soft_rst[gi]) || ch_in[gi].sd_loss_evt;
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          boost_ff[gi] <= BOOST_RST;
          cap_ff[gi]   <= CAP_START_RST;
          lol_ff[gi]   <= 1'b0;
          sdl_ff[gi]   <= 1'b0;
        end else begin
          boost_ff[gi] <= nxt_boost;
          cap_ff[gi]   <= nxt_cap;
          lol_ff[gi]   <= nxt_lol;
          sdl_ff[gi]   <= nxt_sdl;
        end
      end

      always_comb begin
        ch_rd[gi] = UNMAPPED_RD;
        case (reg_addr)
          ADDR_SOFT_RST:   ch_rd[gi] = 8'h00;
          ADDR_INT_FLAGS: begin
            ch_rd[gi][LOCK_LOSS_BIT] = lol_ff[gi];
            ch_rd[gi][SD_LOSS_BIT]   = sdl_ff[gi];
          end
          ADDR_REC_STATUS: ch_rd[gi] = ch_in[gi].status;
          ADDR_EQ_BOOST:   ch_rd[gi] = boost_ff[gi];
          ADDR_CAP_START:  ch_rd[gi] = {3'h0, cap_ff[gi]};
          default:         ch_rd[gi] = UNMAPPED_RD;
        endcase
      end

      assign ch_out[gi].boost_stage_zero  = boost_ff[gi][7:6];
      assign ch_out[gi].boost_stage_one   = boost_ff[gi][5:4];
      assign ch_out[gi].boost_stage_two   = boost_ff[gi][3:2];
      assign ch_out[gi].boost_stage_three = boost_ff[gi][1:0];
      assign ch_out[gi].cap_start         = cap_ff[gi];
      assign ch_out[gi].int_pend          = lol_ff[gi] | sdl_ff[gi];
      // Channel 0 sits in the top flag bit
      assign sh_chint[3-gi] = lol_ff[gi] | sdl_ff[gi];

      a_bcast_write: assert property (
        (wr_ch[gi] && !soft_rst[gi] && reg_addr == ADDR_EQ_BOOST) |=> boost_ff[gi] == $past(reg_wdata))
        else $error("channel boost not updated by write");
      a_soft_reset: assert property (
        soft_rst[gi] |=> (boost_ff[gi] == BOOST_RST && cap_ff[gi] == CAP_START_RST))
        else $error("channel soft reset left values");
      a_flag_sticky: assert property (
        (lol_ff[gi] && !soft_rst[gi]) |=> lol_ff[gi])
        else $error("lock loss flag dropped without reset");
      a_sdl_sticky: assert property (
        (sdl_ff[gi] && !soft_rst[gi]) |=> sdl_ff[gi])
        else $error("signal loss flag dropped without reset");

      // Events must land even when a soft reset hits the same cycle
      a_lol_set: assert property (ch_in[gi].lock_loss_evt |=> lol_ff[gi])
        else $error("lock loss event not captured");
      a_sdl_set: assert property (ch_in[gi].sd_loss_evt |=> sdl_ff[gi])
        else $error("signal loss event not captured");
      a_lol_clear: assert property (
        (soft_rst[gi] && !ch_in[gi].lock_loss_evt) |=> !lol_ff[gi])
        else $error("lock loss flag survived soft reset");
      a_sdl_clear: assert property (
        (soft_rst[gi] && !ch_in[gi].sd_loss_evt) |=> !sdl_ff[gi])
        else $error("signal loss flag survived soft reset");
      a_lol_quiet: assert property (
        (!lol_ff[gi] && !ch_in[gi].lock_loss_evt) |=> !lol_ff[gi])
        else $error("lock loss flag set without event");
      a_sdl_quiet: assert property (
        (!sdl_ff[gi] && !ch_in[gi].sd_loss_evt) |=> !sdl_ff[gi])
        else $error("signal loss flag set without event");

      a_cap_write: assert property (
        (wr_ch[gi] && !soft_rst[gi] && reg_addr == ADDR_CAP_START) |=> cap_ff[gi] == $past(reg_wdata[4:0]))
        else $error("channel cap start not updated by write");
      a_chan_hold: assert property (
        !wr_ch[gi] |=> ($stable(boost_ff[gi]) && $stable(cap_ff[gi])))
        else $error("channel settings changed without its write");
      a_chan_reset: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> (boost_ff[gi] == BOOST_RST && cap_ff[gi] == CAP_START_RST && !lol_ff[gi] && !sdl_ff[gi]))
        else $error("channel state not cleared by reset");
    end
  endgenerate

  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_en) begin
      if (reg_addr == ADDR_SELECT) begin
        nxt_rdata = UNMAPPED_RD;
      end else if (chan_mode) begin
        nxt_rdata = ch_rd[rd_ch];
      end else if (reg_addr == ADDR_SH_CHINT) begin
        nxt_rdata = {4'h0, sh_chint};
      end else begin
        nxt_rdata = UNMAPPED_RD;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= reg_rd_en;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // Assertions

  sequence s_sel_write;
    reg_wr_en && reg_addr == ADDR_SELECT;
  endsequence

  sequence s_chan_read;
    reg_rd_en && chan_mode && reg_addr != ADDR_SELECT;
  endsequence

  a_sel_write: assert property (s_sel_write |=> sel_ff == $past(reg_wdata))
    else $error("select register not loaded");
  a_sel_persist: assert property (!(reg_wr_en && reg_addr == ADDR_SELECT) |=> $stable(sel_ff))
    else $error("selection changed without select write");
  a_sel_no_read: assert property ((reg_rd_en && reg_addr == ADDR_SELECT) |=> reg_rdata == UNMAPPED_RD)
    else $error("select register read back");
  a_read_chan: assert property (s_chan_read |=> reg_rdata == $past(ch_rd[rd_ch]) && reg_rvalid)
    else $error("channel read from wrong channel");
  a_shared_route: assert property ((reg_wr_en && !chan_mode) |-> wr_ch == '0)
    else $error("channel written while shared set selected");
  a_shared_flags: assert property ((reg_rd_en && !chan_mode && reg_addr == ADDR_SH_CHINT)
    |=> reg_rdata[3] == $past(lol_ff[0] | sdl_ff[0]))
    else $error("shared channel interrupt flag wrong");
  // Reset is the antecedent here, so the default disable must not mask it
  a_reset_sel: assert property (@(posedge clk) disable iff (1'b0) srst |=> sel_ff == SELECT_RST)
    else $error("select not zero after reset");
  a_bcast_all: assert property ((reg_wr_en && reg_addr != ADDR_SELECT && sel_ff[3:2] == 2'b11) |-> &wr_ch)
    else $error("broadcast missed a channel");

  sequence s_chan_write;
    reg_wr_en && chan_mode && reg_addr != ADDR_SELECT;
  endsequence

  sequence s_shared_read;
    reg_rd_en && !chan_mode && reg_addr != ADDR_SELECT;
  endsequence

  sequence s_flags_read;
    reg_rd_en && chan_mode && reg_addr == ADDR_INT_FLAGS;
  endsequence

  // Read answer is valid one cycle after each read strobe cycle; data holds until the next read
  a_rvalid_pulse: assert property (reg_rd_en |=> reg_rvalid)
    else $error("read answer missing");
  a_rvalid_idle: assert property (!reg_rd_en |=> !reg_rvalid)
    else $error("read answer without read");
  a_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_reset_bus: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> (!reg_rvalid && reg_rdata == 8'h00))
    else $error("read port not idle after reset");

  a_shared_answer: assert property (s_shared_read |=> reg_rvalid)
    else $error("shared read not answered");
  a_shared_unmapped: assert property ((reg_rd_en && !chan_mode && reg_addr != ADDR_SH_CHINT)
    |=> reg_rdata == UNMAPPED_RD)
    else $error("unmapped shared read not zero");
  a_shared_nibble: assert property ((reg_rd_en && !chan_mode && reg_addr == ADDR_SH_CHINT)
    |=> reg_rdata == {4'h0, $past(lol_ff[0] | sdl_ff[0]), $past(lol_ff[1] | sdl_ff[1]),
                      $past(lol_ff[2] | sdl_ff[2]), $past(lol_ff[3] | sdl_ff[3])})
    else $error("shared interrupt flags wrong");

  a_chan_target: assert property (s_chan_write |-> wr_ch != '0)
    else $error("channel write reached no channel");
  a_single_target: assert property (
    (reg_wr_en && chan_mode && !sel_ff[SEL_BCAST_BIT] && reg_addr != ADDR_SELECT)
    |-> wr_ch == (N_CH'(1) << rd_ch))
    else $error("targeted write hit wrong channel");
  a_sel_no_chan: assert property ((reg_wr_en && reg_addr == ADDR_SELECT) |-> wr_ch == '0)
    else $error("select write reached a channel");
  a_idle_no_write: assert property (!reg_wr_en |-> (wr_ch == '0 && soft_rst == '0))
    else $error("channel written without strobe");
  a_bcast_gated: assert property ((reg_wr_en && !chan_mode) |-> soft_rst == '0)
    else $error("soft reset while shared set selected");
  a_bcast_reset: assert property (
    (reg_wr_en && chan_mode && sel_ff[SEL_BCAST_BIT] && reg_addr == ADDR_SOFT_RST && reg_wdata[SOFT_RST_BIT])
    |-> &soft_rst)
    else $error("broadcast soft reset missed a channel");

  a_flags_read: assert property (s_flags_read
    |=> reg_rdata == {3'h0, $past(lol_ff[rd_ch]), 3'h0, $past(sdl_ff[rd_ch])})
    else $error("channel flag read wrong");
  a_status_read: assert property ((reg_rd_en && chan_mode && reg_addr == ADDR_REC_STATUS)
    |=> reg_rdata == $past(ch_in[rd_ch].status))
    else $error("recovery status read wrong");
  a_boost_read: assert property ((reg_rd_en && chan_mode && reg_addr == ADDR_EQ_BOOST)
    |=> reg_rdata == $past(boost_ff[rd_ch]))
    else $error("boost read wrong");
  a_cap_read: assert property ((reg_rd_en && chan_mode && reg_addr == ADDR_CAP_START)
    |=> reg_rdata == {3'h0, $past(cap_ff[rd_ch])})
    else $error("cap start read wrong");
  a_rstreg_read: assert property ((reg_rd_en && chan_mode && reg_addr == ADDR_SOFT_RST)
    |=> reg_rdata == 8'h00)
    else $error("self clearing reset bit read back");
endmodule : qcr_banking

/* qcr_host_model.sv */
// Host side model issuing register strobes to the banking block
`timescale 1ns/10ps
module qcr_host_model (
  input  wire logic       clk,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h5A;
    wdata = 8'hA5;
  end
  // Whole byte every time, select bits written exactly as given
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    // Released lines show inverse so stale data never looks valid
    addr  = ~addr;
    wdata = ~wdata;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    rd_en = 1'b1;
    addr  = a;
    @(negedge clk);
    d     = rdata;
    v     = rvalid;
    rd_en = 1'b0;
    addr  = ~addr;
  endtask : rd
endmodule : qcr_host_model

/* tb_top.sv */
// Self-checking testbench for the register banking block
`timescale 1ns/10ps
module tb_top;
  import qcr_pkg::*;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              wr_en, rd_en, rvalid;
  logic [7:0]        addr, wdata, rdata, d;
  qcr_ch_in_t [3:0]  ch_in;
  qcr_ch_out_t [3:0] ch_out;
  int                fail_count = 0;
  int                n_compared = 0;
  always #5 clk = ~clk;
  qcr_banking uut (.clk(clk), .srst(srst), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .ch_in(ch_in), .ch_out(ch_out));
  qcr_host_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic v;
    host.rd(a, d, v);
    chk({name, " valid"}, 8'h01, {7'h00, v});
    chk(name, exp, d);
  endtask : rd_chk
  function automatic logic [7:0] cfg(input int i);
    return {ch_out[i].boost_stage_zero, ch_out[i].boost_stage_one, ch_out[i].boost_stage_two,
            ch_out[i].boost_stage_three};
  endfunction : cfg
  task automatic give_verdict;
    $display("Mismatches %0d, comparisons %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 4; i++) ch_in[i] = '{1'b0, 1'b0, 8'h5A ^ 8'(i)};
    repeat (8) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      chk("boost rst", 8'h00, cfg(i));
      chk("cap rst", 8'h00, {3'h0, ch_out[i].cap_start});
    end
    rd_chk("shared int rst", ADDR_SH_CHINT, 8'h00);
    rd_chk("select read", ADDR_SELECT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.wr(ADDR_SELECT, 8'h04 + 8'(i));
      host.wr(ADDR_EQ_BOOST, 8'(8'h1B * (i + 1)));
      host.wr(ADDR_CAP_START, 8'hE1 + 8'(i));
    end
    // Readback after all writes proves the four copies stay apart
    for (int i = 0; i < 4; i++) begin
      host.wr(ADDR_SELECT, 8'h04 + 8'(i));
      rd_chk("boost", ADDR_EQ_BOOST, 8'(8'h1B * (i + 1)));
      rd_chk("cap", ADDR_CAP_START, 8'(i + 1));
      rd_chk("status", ADDR_REC_STATUS, 8'h5A ^ 8'(i));
      chk("boost out", 8'(8'h1B * (i + 1)), cfg(i));
    end
    host.wr(ADDR_SELECT, 8'h0D);
    host.wr(ADDR_EQ_BOOST, 8'hE4);
    for (int i = 0; i < 4; i++) chk("bcast out", 8'hE4, cfg(i));
    for (int i = 0; i < 4; i++) begin
      host.wr(ADDR_SELECT, 8'h0C + 8'(i));
      rd_chk("bcast boost", ADDR_EQ_BOOST, 8'hE4);
      rd_chk("bcast cap", ADDR_CAP_START, 8'(i + 1));
      rd_chk("bcast status", ADDR_REC_STATUS, 8'h5A ^ 8'(i));
    end
    @(negedge clk);
    ch_in[2].lock_loss_evt = 1'b1;
    ch_in[0].sd_loss_evt   = 1'b1;
    @(negedge clk);
    ch_in[2].lock_loss_evt = 1'b0;
    ch_in[0].sd_loss_evt   = 1'b0;
    host.wr(ADDR_SELECT, 8'h06);
    rd_chk("lock loss", ADDR_INT_FLAGS, 8'h10);
    host.wr(ADDR_SELECT, 8'h04);
    rd_chk("sd loss", ADDR_INT_FLAGS, 8'h01);
    chk("int pend", 8'h05, {4'h0, ch_out[3].int_pend, ch_out[2].int_pend, ch_out[1].int_pend,
      ch_out[0].int_pend});
    host.wr(ADDR_SELECT, 8'h08);
    rd_chk("shared int", ADDR_SH_CHINT, 8'h0A);
    host.wr(ADDR_SELECT, 8'h06);
    host.wr(ADDR_SOFT_RST, 8'h04);
    rd_chk("soft clear", ADDR_SOFT_RST, 8'h00);
    rd_chk("flags clear", ADDR_INT_FLAGS, 8'h00);
    chk("boost clear", 8'h00, cfg(2));
    chk("cap clear", 8'h00, {3'h0, ch_out[2].cap_start});
    chk("other kept", 8'hE4, cfg(1));
    // Select is reachable even while a channel set is routed
    host.wr(ADDR_SELECT, 8'h00);
    rd_chk("shared back", ADDR_SH_CHINT, 8'h08);
    give_verdict();
  end
endmodule : tb_top
